// file: common/pss_pkg.sv
package pss_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ             = 100_000_000;
  localparam int unsigned RESET_CYCLES       = 512;
  localparam int unsigned INIT_CYCLES        = 128;
  localparam int unsigned SOFT_EXIT_CYCLES   = 512;
  localparam int unsigned STANDBY_OSC_EDGES  = 4;
  localparam int unsigned PD_MIN_NS          = 100_000;
  localparam int unsigned PD_MIN_CYCLES      = (PD_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned HOST_SETTLE_CYCLES = 4;

  localparam int unsigned CNT_W = 10;
  localparam int unsigned SBY_W = 3;
  localparam int unsigned PD_W  = 16;
  localparam logic [CNT_W-1:0] RESET_LAST  = CNT_W'(RESET_CYCLES - 1);
  localparam logic [CNT_W-1:0] INIT_LAST   = CNT_W'(INIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] SOFT_LAST   = CNT_W'(SOFT_EXIT_CYCLES - 1);
  localparam logic [SBY_W-1:0] SBY_LAST    = SBY_W'(STANDBY_OSC_EDGES - 1);
  localparam logic [PD_W-1:0]  SETTLE_LAST = PD_W'(HOST_SETTLE_CYCLES - 1);

  // ****************************************
  // device register map and fields
  // ****************************************
  localparam logic [5:0] ADDR_PAGE   = 6'h00;
  localparam logic [5:0] ADDR_CMD    = 6'h01;
  localparam logic [5:0] ADDR_CTRL   = 6'h09;
  localparam logic [5:0] ADDR_IRQCFG = 6'h2D;
  localparam logic [5:0] INIT_FIRST  = 6'h10;
  localparam logic [5:0] CMD_STARTUP = 6'h3F;
  localparam logic [5:0] CMD_IDLE    = 6'h00;
  localparam logic [7:0] PAGE_DETECT = 8'h80;
  localparam logic [7:0] PAGE_LINEAR = 8'h00;
  localparam int unsigned CTRL_RXAUTO_BIT = 3;
  localparam int unsigned CTRL_SOFT_BIT   = 4;
  localparam int unsigned CTRL_SBY_BIT    = 5;
  localparam int unsigned IRQ_CMOS_BIT    = 0;
  localparam int unsigned IRQ_INV_BIT     = 1;
  // init copy: one byte every 4 cycles, 32 bytes in 128 cycles
  localparam int unsigned INIT_STEP_W = 2;
  localparam int unsigned INIT_IDX_W  = 5;
  localparam logic [INIT_STEP_W-1:0] INIT_STEP_LAST = 2'h3;

  // ****************************************
  // host avalon map (byte addresses)
  // ****************************************
  localparam logic [3:0] AV_CTRL     = 4'h0;
  localparam logic [3:0] AV_STATUS   = 4'h4;
  localparam logic [3:0] AV_ACCESS   = 4'h8;
  localparam logic [3:0] AV_LINKDATA = 4'hC;
  localparam int unsigned AV_START_BIT = 0;
  localparam int unsigned ACC_READ_BIT = 16;

  typedef enum logic [1:0] {PSS_HARD_PD, PSS_RESET, PSS_INIT, PSS_IDLE} pss_phase_t;

endpackage

// file: common/pss_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pss_link_if (
  input wire logic clk
);
  logic [5:0] addr;
  logic [7:0] wrData;
  logic       write;
  logic       read;
  logic [7:0] rdData;
  logic       powerDownResetPin;

  modport device (input addr, input wrData, input write, input read, input powerDownResetPin, output rdData);
  modport host (output addr, output wrData, output write, output read, output powerDownResetPin, input rdData);
endinterface
`default_nettype wire

// file: core/pss_device.sv
// Functional notes
// - reset pin high forces hard power-down, sinks, oscillator and buffers off
// - hard power-down isolates inputs except reset pin
// - frozen: irq/aux hi-z, data low, osc high
// - driver 1 follows carrier enable one in power-down
// - driver 2 in power-down high only enable2 and not inverted
// - soft bit set enters soft power-down immediately
// - soft exit after 512 cycles, bit self-clears
// - standby bit stops clock buffer, oscillator runs
// - standby exits after four oscillator edges, self-clears
// - receiver auto off powers receiver only when used
// - power-down during reset, low supply, pin high
// - host holds reset pin at least 100 us
// - reset phase 512 cycles presets register bits
// - 128-cycle init copies memory to 10h-2Fh
// - command reads 3Fh at start-up, 00h idle
// - host polls command until 00h before control
// - page 80h then command read 00h detects
// - page 00h then selects linear addressing
// - reset phase presets irq invert 1, cmos 0
`timescale 1ns/1ps
`default_nettype none
module pss_device (
  input  wire logic              clk,
  input  wire logic              reset_n,
  pss_link_if.device             link,
  input  wire logic              supplyOk,
  input  wire logic              oscStable,
  input  wire logic              oscInput,
  input  wire logic              receiverInUse,
  input  wire logic              irqLevel,
  input  wire logic              auxEnable,
  input  wire logic              auxSrc,
  input  wire logic              serialDataSrc,
  input  wire logic              oscDriveSrc,
  input  wire logic              carrierSrc1,
  input  wire logic              carrierSrc2,
  input  wire logic              tx1CarrierEnable,
  input  wire logic              tx2CarrierEnable,
  input  wire logic              tx2Invert,
  input  wire logic [7:0]        nvmData,
  output logic [4:0]             nvmAddr,
  output logic                   cfgWrite,
  output logic [5:0]             cfgAddr,
  output logic [7:0]             cfgData,
  output logic                   presetRegs,
  output pss_pkg::pss_phase_t    phase,
  output logic [5:0]             commandValue,
  output logic                   softPowerDown,
  output logic                   standbyActive,
  output logic                   currentSinksOn,
  output logic                   oscillatorOn,
  output logic                   oscBufferOn,
  output logic                   clockBufferOn,
  output logic                   inputsIsolated,
  output logic                   receiverPowered,
  output logic                   irqOut,
  output logic                   irqOe,
  output logic                   auxOut,
  output logic                   auxOe,
  output logic                   serialDataOut,
  output logic                   oscOutput,
  output logic                   antennaDriver1,
  output logic                   antennaDriver2,
  output logic                   linearAddressing,
  output logic                   interfaceDetected
);
  import pss_pkg::*;

  // ****************************************
  // synchronisers
  // ****************************************
  logic pinS1_reg, pinS2_reg, supS1_reg, supS2_reg, oscStS1_reg, oscStS2_reg;
  logic oscS1_reg, oscS2_reg, oscS3_reg;

  always_ff @(posedge clk)
  begin
    pinS1_reg   <= link.powerDownResetPin;
    pinS2_reg   <= pinS1_reg;
    supS1_reg   <= supplyOk;
    supS2_reg   <= supS1_reg;
    oscStS1_reg <= oscStable;
    oscStS2_reg <= oscStS1_reg;
    oscS1_reg   <= oscInput;
    oscS2_reg   <= oscS1_reg;
    oscS3_reg   <= oscS2_reg;
  end

  // pin comes from same-clock host logic, so its raw level may assert at once;
  // the synchronised copy stretches it so release waits two edges
  wire hardPd  = link.powerDownResetPin | pinS2_reg | ~supS2_reg;
  wire oscEdge = oscS2_reg & ~oscS3_reg;

  // ****************************************
  // start-up sequencer
  // ****************************************
  pss_phase_t       phase_reg, phase_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;

  always_comb
  begin
    phase_next = phase_reg;
    cnt_next   = cnt_reg;
    if (hardPd)
    begin
      phase_next = PSS_HARD_PD;
      cnt_next   = '0;
    end
    else
    begin
      unique case (phase_reg)
        PSS_HARD_PD:
        begin
          phase_next = PSS_RESET;
          cnt_next   = '0;
        end
        PSS_RESET:
        begin
          if (oscStS2_reg)
          begin
            if (cnt_reg == RESET_LAST)
            begin
              phase_next = PSS_INIT;
              cnt_next   = '0;
            end
            else
              cnt_next = cnt_reg + 1'b1;
          end
        end
        PSS_INIT:
        begin
          if (cnt_reg == INIT_LAST)
          begin
            phase_next = PSS_IDLE;
            cnt_next   = '0;
          end
          else
            cnt_next = cnt_reg + 1'b1;
        end
        PSS_IDLE: ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      phase_reg <= PSS_HARD_PD;
      cnt_reg   <= '0;
    end
    else
    begin
      phase_reg <= phase_next;
      cnt_reg   <= cnt_next;
    end
  end

  // ****************************************
  // initialization copy
  // ****************************************
  wire [INIT_IDX_W-1:0] initIdx  = cnt_reg[INIT_STEP_W +: INIT_IDX_W];
  wire                  initTake = (phase_reg == PSS_INIT) && (cnt_reg[INIT_STEP_W-1:0] == INIT_STEP_LAST);
  logic cfgWrite_reg;
  logic [5:0] cfgAddr_reg;
  logic [7:0] cfgData_reg;

  // memory gets four cycles per address, so its data is settled when taken
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cfgWrite_reg <= 1'b0;
      cfgAddr_reg  <= INIT_FIRST;
      cfgData_reg  <= 8'h00;
    end
    else
    begin
      cfgWrite_reg <= initTake;
      cfgAddr_reg  <= INIT_FIRST + 6'(initIdx);
      cfgData_reg  <= nvmData;
    end
  end

  // ****************************************
  // host-side register access
  // ****************************************
  wire busOk   = ~hardPd;
  wire isIdle  = (phase_reg == PSS_IDLE);
  wire wrEn    = link.write & busOk;
  wire rdEn    = link.read & busOk;
  wire wrPage  = wrEn && (link.addr == ADDR_PAGE);
  wire wrCtrl  = wrEn && isIdle && (link.addr == ADDR_CTRL);
  wire wrIrq   = wrEn && isIdle && (link.addr == ADDR_IRQCFG);
  wire wrCmd   = wrEn && isIdle && (link.addr == ADDR_CMD);
  wire softWr  = link.wrData[CTRL_SOFT_BIT];
  wire sbyWr   = link.wrData[CTRL_SBY_BIT];

  logic [5:0] cmd_reg;
  logic [7:0] page_reg, rdData_reg;
  logic       armed_reg, detected_reg, linear_reg;
  logic       irq_polarity_invert_reg, irqCmos_reg, rxAuto_reg;
  logic       soft_reg, softExit_reg, sby_reg, sbyExit_reg;
  logic [CNT_W-1:0] softCnt_reg;
  logic [SBY_W-1:0] sbyCnt_reg;

  wire [7:0] ctrlRead = 8'({sby_reg, soft_reg, rxAuto_reg}) << CTRL_RXAUTO_BIT;
  wire [7:0] irqRead  = 8'({irq_polarity_invert_reg, irqCmos_reg}) << IRQ_CMOS_BIT;
  wire [7:0] rdMux    = (link.addr == ADDR_PAGE)   ? page_reg :
                        (link.addr == ADDR_CMD)    ? {2'h0, cmd_reg} :
                        (link.addr == ADDR_CTRL)   ? ctrlRead :
                        (link.addr == ADDR_IRQCFG) ? irqRead : 8'h00;

  always_ff @(posedge clk)
  begin
    if (!reset_n || !isIdle)
    begin
      cmd_reg      <= (reset_n && phase_next == PSS_IDLE) ? CMD_IDLE : CMD_STARTUP;
      armed_reg    <= 1'b0;
      detected_reg <= 1'b0;
      linear_reg   <= 1'b0;
      rxAuto_reg   <= 1'b0;
    end
    else
    begin
      if (wrCmd)
        cmd_reg <= link.wrData[5:0];
      if (wrCtrl)
        rxAuto_reg <= link.wrData[CTRL_RXAUTO_BIT];
      if (wrPage && link.wrData == PAGE_DETECT)
        armed_reg <= 1'b1;
      if (rdEn && armed_reg && link.addr == ADDR_CMD && cmd_reg == CMD_IDLE)
        detected_reg <= 1'b1;
      if (wrPage && link.wrData == PAGE_LINEAR && detected_reg)
        linear_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      page_reg   <= 8'h00;
      rdData_reg <= 8'h00;
    end
    else
    begin
      if (wrPage)
        page_reg <= link.wrData;
      if (rdEn)
        rdData_reg <= rdMux;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n || phase_reg == PSS_RESET)
    begin
      irq_polarity_invert_reg  <= 1'b1;
      irqCmos_reg <= 1'b0;
    end
    else if (wrIrq)
    begin
      irq_polarity_invert_reg  <= link.wrData[IRQ_INV_BIT];
      irqCmos_reg <= link.wrData[IRQ_CMOS_BIT];
    end
  end

  // ****************************************
  // soft power-down and standby
  // ****************************************
  // writing the bit low only arms the exit; the bit keeps reading high until it ends
  always_ff @(posedge clk)
  begin
    if (!reset_n || !isIdle)
    begin
      soft_reg     <= 1'b0;
      softExit_reg <= 1'b0;
      softCnt_reg  <= '0;
    end
    else if (wrCtrl && softWr)
    begin
      soft_reg     <= 1'b1;
      softExit_reg <= 1'b0;
    end
    else if (wrCtrl && soft_reg && !softExit_reg)
    begin
      softExit_reg <= 1'b1;
      softCnt_reg  <= '0;
    end
    else if (softExit_reg)
    begin
      if (softCnt_reg == SOFT_LAST)
      begin
        soft_reg     <= 1'b0;
        softExit_reg <= 1'b0;
      end
      else
        softCnt_reg <= softCnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n || !isIdle)
    begin
      sby_reg     <= 1'b0;
      sbyExit_reg <= 1'b0;
      sbyCnt_reg  <= '0;
    end
    else if (wrCtrl && sbyWr)
    begin
      sby_reg     <= 1'b1;
      sbyExit_reg <= 1'b0;
    end
    else if (wrCtrl && sby_reg && !sbyExit_reg)
    begin
      sbyExit_reg <= 1'b1;
      sbyCnt_reg  <= '0;
    end
    else if (sbyExit_reg && oscEdge)
    begin
      if (sbyCnt_reg == SBY_LAST)
      begin
        sby_reg     <= 1'b0;
        sbyExit_reg <= 1'b0;
      end
      else
        sbyCnt_reg <= sbyCnt_reg + 1'b1;
    end
  end

  // ****************************************
  // pads
  // ****************************************
  wire irqLvl = irqLevel ^ irq_polarity_invert_reg;
  logic irqOut_reg, irqOe_reg, auxOut_reg, auxOe_reg, sdo_reg, osc_output_reg, ant1_reg, ant2_reg;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      irqOut_reg <= 1'b0;
      irqOe_reg  <= 1'b0;
      auxOut_reg <= 1'b0;
      auxOe_reg  <= 1'b0;
      sdo_reg    <= 1'b0;
      osc_output_reg <= 1'b1;
      ant1_reg   <= 1'b0;
      ant2_reg   <= 1'b0;
    end
    else if (hardPd)
    begin
      irqOe_reg  <= 1'b0;
      auxOe_reg  <= 1'b0;
      sdo_reg    <= 1'b0;
      osc_output_reg <= 1'b1;
      ant1_reg   <= tx1CarrierEnable;
      ant2_reg   <= tx2CarrierEnable & ~tx2Invert;
    end
    else if (!soft_reg && !sby_reg)
    begin
      // open drain pulls low only; the line idles high-impedance
      irqOut_reg <= irqCmos_reg & irqLvl;
      irqOe_reg  <= irqCmos_reg | ~irqLvl;
      auxOut_reg <= auxSrc;
      auxOe_reg  <= auxEnable;
      sdo_reg    <= serialDataSrc;
      osc_output_reg <= oscDriveSrc;
      ant1_reg   <= carrierSrc1;
      ant2_reg   <= carrierSrc2;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic hardPd_reg;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      hardPd_reg <= 1'b1;
    else
      hardPd_reg <= hardPd;
  end

  assign currentSinksOn    = ~hardPd_reg & ~soft_reg & ~sby_reg;
  assign oscillatorOn      = ~hardPd_reg;
  assign oscBufferOn       = ~hardPd_reg & ~soft_reg;
  assign clockBufferOn     = ~hardPd_reg & ~sby_reg;
  assign inputsIsolated    = hardPd_reg;
  assign receiverPowered   = currentSinksOn & (~rxAuto_reg | receiverInUse);
  assign softPowerDown     = soft_reg;
  assign standbyActive     = sby_reg;
  assign nvmAddr           = initIdx;
  assign cfgWrite          = cfgWrite_reg;
  assign cfgAddr           = cfgAddr_reg;
  assign cfgData           = cfgData_reg;
  assign presetRegs        = (phase_reg == PSS_RESET);
  assign phase             = phase_reg;
  assign commandValue      = cmd_reg;
  assign linearAddressing  = linear_reg;
  assign interfaceDetected = detected_reg;
  assign link.rdData       = rdData_reg;
  assign irqOut            = irqOut_reg;
  assign irqOe             = irqOe_reg;
  assign auxOut            = auxOut_reg;
  assign auxOe             = auxOe_reg;
  assign serialDataOut     = sdo_reg;
  assign oscOutput         = osc_output_reg;
  assign antennaDriver1    = ant1_reg;
  assign antennaDriver2    = ant2_reg;

endmodule // pss_device
`default_nettype wire

// file: core/pss_host.sv
`timescale 1ns/1ps
`default_nettype none
module pss_host #(
  parameter int unsigned PD_HOLD_CYCLES = pss_pkg::PD_MIN_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  output logic [31:0]      avsReadData,
  output logic             avsWaitrequest,
  pss_link_if.host         link
);
  import pss_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {H_IDLE, H_PD, H_SETTLE, H_OP, H_WAIT1, H_WAIT2} pss_hstate_t;
  typedef enum logic [2:0] {S_POLL, S_PAGE80, S_CHECK, S_PAGE00, S_USER} pss_step_t;

  pss_hstate_t st_reg;
  pss_step_t   step_reg;
  logic [PD_W-1:0] cnt_reg;
  logic       pin_reg, rd_reg, wr_reg, done_reg, ready_reg, fail_reg;
  logic [5:0] addr_reg, accAddr_reg;
  logic [7:0] data_reg, accData_reg, linkData_reg;
  logic       accRead_reg;
  logic [31:0] rdOut_reg;

  wire req       = avsRead | avsWrite;
  wire accReq    = avsWrite && (avsAddress == AV_ACCESS);
  wire startReq  = avsWrite && (avsAddress == AV_CTRL) && avsWriteData[AV_START_BIT];
  wire busy      = (st_reg != H_IDLE);
  wire launchAcc = accReq && !busy && !done_reg;
  wire simpleAck = req && !accReq && !done_reg;

  // ****************************************
  // step decode
  // ****************************************
  wire stepRead = (step_reg == S_POLL) || (step_reg == S_CHECK) || (step_reg == S_USER && accRead_reg);
  wire [5:0] stepAddr = (step_reg == S_USER) ? accAddr_reg :
                        (step_reg == S_PAGE80 || step_reg == S_PAGE00) ? ADDR_PAGE : ADDR_CMD;
  wire [7:0] stepData = (step_reg == S_USER) ? accData_reg :
                        (step_reg == S_PAGE80) ? PAGE_DETECT : PAGE_LINEAR;
  wire cmdIsIdle = (link.rdData[5:0] == CMD_IDLE);
  wire [PD_W-1:0] pdLast = PD_W'(PD_HOLD_CYCLES - 1);
  wire [31:0] statusWord = {28'h0, fail_reg, ready_reg, ready_reg, busy};
  wire [31:0] rdMux = (avsAddress == AV_STATUS)   ? statusWord :
                      (avsAddress == AV_LINKDATA) ? {24'h0, linkData_reg} : 32'h0;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_reg       <= H_IDLE;
      step_reg     <= S_POLL;
      cnt_reg      <= '0;
      pin_reg      <= 1'b1;
      rd_reg       <= 1'b0;
      wr_reg       <= 1'b0;
      addr_reg     <= 6'h00;
      data_reg     <= 8'h00;
      ready_reg    <= 1'b0;
      fail_reg     <= 1'b0;
      accAddr_reg  <= 6'h00;
      accData_reg  <= 8'h00;
      accRead_reg  <= 1'b0;
      linkData_reg <= 8'h00;
      done_reg     <= 1'b0;
      rdOut_reg    <= 32'h0;
    end
    else
    begin
      done_reg <= simpleAck;
      if (simpleAck)
        rdOut_reg <= rdMux;
      unique case (st_reg)
        H_IDLE:
        begin
          if (startReq)
          begin
            st_reg    <= H_PD;
            pin_reg   <= 1'b1;
            cnt_reg   <= '0;
            ready_reg <= 1'b0;
            fail_reg  <= 1'b0;
          end
          else if (launchAcc)
          begin
            accAddr_reg <= avsWriteData[5:0];
            accData_reg <= avsWriteData[15:8];
            accRead_reg <= avsWriteData[ACC_READ_BIT];
            step_reg    <= S_USER;
            st_reg      <= H_OP;
          end
        end
        H_PD:
        begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == pdLast)
          begin
            pin_reg <= 1'b0;
            cnt_reg <= '0;
            st_reg  <= H_SETTLE;
          end
        end
        H_SETTLE:
        begin
          // reads are ignored until the device sees the release
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == SETTLE_LAST)
          begin
            step_reg <= S_POLL;
            st_reg   <= H_OP;
          end
        end
        H_OP:
        begin
          rd_reg   <= stepRead;
          wr_reg   <= ~stepRead;
          addr_reg <= stepAddr;
          data_reg <= stepData;
          st_reg   <= H_WAIT1;
        end
        H_WAIT1:
        begin
          rd_reg <= 1'b0;
          wr_reg <= 1'b0;
          st_reg <= H_WAIT2;
        end
        H_WAIT2:
        begin
          st_reg <= H_OP;
          unique case (step_reg)
            S_POLL:
              if (cmdIsIdle)
                step_reg <= S_PAGE80;
            S_PAGE80:
              step_reg <= S_CHECK;
            S_CHECK:
              if (cmdIsIdle)
                step_reg <= S_PAGE00;
              else
              begin
                fail_reg <= 1'b1;
                st_reg   <= H_IDLE;
              end
            S_PAGE00:
            begin
              ready_reg <= 1'b1;
              st_reg    <= H_IDLE;
            end
            S_USER:
            begin
              if (accRead_reg)
                linkData_reg <= link.rdData;
              done_reg <= 1'b1;
              st_reg   <= H_IDLE;
            end
          endcase
        end
      endcase
    end
  end

  assign avsWaitrequest         = req & ~done_reg;
  assign avsReadData            = rdOut_reg;
  assign link.powerDownResetPin = pin_reg;
  assign link.read              = rd_reg;
  assign link.write             = wr_reg;
  assign link.addr              = addr_reg;
  assign link.wrData            = data_reg;

endmodule // pss_host
`default_nettype wire

// file: dv/pss_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pss_chk #(
  parameter int unsigned HOLD = 20
) (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [5:0] addr,
  input wire logic [7:0] wrData,
  input wire logic       write,
  input wire logic       read,
  input wire logic [7:0] rdData,
  input wire logic       powerDownResetPin
);
  import pss_pkg::*;
  logic [15:0] pdCnt_reg;
  always_ff @(posedge clk)
    if (!reset_n)
      pdCnt_reg <= 16'h0;
    else
      pdCnt_reg <= powerDownResetPin ? pdCnt_reg + 16'h1 : 16'h0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  strobe_excl_a: assert property (!(read && write))
    else $error("read and write together");
  strobe_gap_a: assert property (read || write |=> (!read && !write) [*2])
    else $error("strobes too close");
  rd_hold_a: assert property ($changed(rdData) |-> $past(read) || $past(read, 2) || $past(read, 3))
    else $error("read data moved");
  pd_quiet_a: assert property (powerDownResetPin |-> !read && !write)
    else $error("strobe in power-down");
  pd_width_a: assert property ($fell(powerDownResetPin) |-> pdCnt_reg >= 16'(HOLD))
    else $error("pulse short");
  pd_settle_a: assert property ($fell(powerDownResetPin) |-> (!read && !write) [*4])
    else $error("no settle");
  page_val_a: assert property (write && addr == ADDR_PAGE |-> wrData == PAGE_DETECT || wrData == PAGE_LINEAR)
    else $error("bad page value");
  detect_read_a: assert property (write && addr == ADDR_PAGE && wrData == PAGE_DETECT
    |-> ##[3:40] (read && addr == ADDR_CMD))
    else $error("no command read");
  cover property ($fell(powerDownResetPin));
  cover property (write && addr == ADDR_CTRL);
  cover property (write && wrData == PAGE_LINEAR);
endmodule // pss_chk
`default_nettype wire

// file: dv/power_startup_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module power_startup_sequencer_tb;
  import pss_pkg::*;
  logic clk = 1'h0, reset_n = 1'h0, supplyOk = 1'h1, oscStable = 1'h1, oscInput = 1'h0, receiverInUse = 1'h0;
  logic irqLevel = 1'h0, auxEnable = 1'h0, auxSrc = 1'h0, serialDataSrc = 1'h0, oscDriveSrc = 1'h0;
  logic carrierSrc1 = 1'h0, carrierSrc2 = 1'h0, tx1CarrierEnable = 1'h0, tx2CarrierEnable = 1'h0, tx2Invert = 1'h0;
  logic avsRead = 1'h0, avsWrite = 1'h0;
  logic [3:0] avsAddress = 4'h0;
  logic [31:0] avsWriteData = 32'h0, avsReadData, rd;
  logic avsWaitrequest, cfgWrite, presetRegs, softPowerDown, standbyActive, currentSinksOn, oscillatorOn;
  logic oscBufferOn, clockBufferOn, inputsIsolated, receiverPowered, irqOe, auxOe, serialDataOut, oscOutput;
  logic antennaDriver1, antennaDriver2, linearAddressing, interfaceDetected;
  logic [4:0] nvmAddr;
  logic [5:0] cfgAddr, commandValue;
  logic [7:0] cfgData;
  wire [7:0] nvmData = {3'h5, nvmAddr};
  pss_phase_t phase;
  int failures = 0, n_tests = 0, k, n, v, nCfg, seed = 32'h6187;
  always #5 clk = ~clk;
  always @(posedge clk)
    {irqLevel, auxEnable, auxSrc, serialDataSrc, oscDriveSrc, carrierSrc1, carrierSrc2} <= 7'($random(seed));
  pss_link_if lnk (.clk);
  pss_device pss_device_inst (.clk, .reset_n, .link(lnk), .supplyOk, .oscStable, .oscInput, .receiverInUse,
    .irqLevel, .auxEnable, .auxSrc, .serialDataSrc, .oscDriveSrc, .carrierSrc1, .carrierSrc2, .tx1CarrierEnable,
    .tx2CarrierEnable, .tx2Invert, .nvmData, .nvmAddr, .cfgWrite, .cfgAddr, .cfgData, .presetRegs, .phase,
    .commandValue, .softPowerDown, .standbyActive, .currentSinksOn, .oscillatorOn, .oscBufferOn, .clockBufferOn,
    .inputsIsolated, .receiverPowered, .irqOut(), .irqOe, .auxOut(), .auxOe, .serialDataOut, .oscOutput,
    .antennaDriver1, .antennaDriver2, .linearAddressing, .interfaceDetected);
  pss_host #(.PD_HOLD_CYCLES(20)) pss_host_inst (.clk, .reset_n, .avsAddress, .avsRead, .avsWrite,
    .avsWriteData, .avsReadData, .avsWaitrequest, .link(lnk));
  pss_chk #(.HOLD(20)) pss_chk_inst (.clk, .reset_n, .addr(lnk.addr), .wrData(lnk.wrData),
    .write(lnk.write), .read(lnk.read), .rdData(lnk.rdData), .powerDownResetPin(lnk.powerDownResetPin));
  task automatic report_and_stop;
    if (failures == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask
  // request held until waitrequest is low at an edge
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= d;
    do
      @(posedge clk);
    while (avsWaitrequest !== 1'h0);
    rd = avsReadData;
    avsWrite <= 1'h0;
    avsRead <= 1'h0;
  endtask
  task automatic acc(input logic [7:0] d);
    av(1'h1, AV_ACCESS, {16'h0, d, 2'h0, ADDR_CTRL});
  endtask
  task automatic cnt(input pss_phase_t p, input int exp);
    n = 0;
    while (phase === p && n < 2000)
    begin
      chk(presetRegs, p == PSS_RESET);
      n++;
      @(posedge clk);
    end
    chk(n, exp);
  endtask
  task automatic seq;
    nCfg = 0;
    k = 0;
    while (phase !== PSS_RESET && k++ < 300)
      @(posedge clk);
    cnt(PSS_RESET, 512);
    cnt(PSS_INIT, 128);
    chk({phase, commandValue, nCfg}, {PSS_IDLE, CMD_IDLE, 32'd32});
  endtask
  always @(negedge clk)
    if (cfgWrite === 1'h1)
    begin
      nCfg++;
      chk({cfgAddr >= 6'h10 && cfgAddr <= 6'h2F, cfgData}, {1'h1, 3'h5, 5'(cfgAddr - 6'h10)});
    end
  initial
  begin
    #200_000;
    failures++;
    report_and_stop;
  end
  initial
  begin
    wt(4);
    reset_n <= 1'h1;
    for (int i = 0; i < 8; i++)
    begin
      {tx1CarrierEnable, tx2CarrierEnable, tx2Invert} <= 3'(i);
      wt(3);
      chk({phase, commandValue, antennaDriver1, antennaDriver2, irqOe, auxOe, serialDataOut, oscOutput, oscillatorOn,
        currentSinksOn, inputsIsolated}, {PSS_HARD_PD, CMD_STARTUP, i[2], i[1] & !i[0], 7'h09});
    end
    for (int r = 0; r < 2; r++)
    begin
      av(1'h1, AV_CTRL, 32'h1);
      seq;
      rd = 32'h0;
      for (v = 0; v < 50 && rd[1] !== 1'h1; v++)
        av(1'h0, AV_STATUS, 32'h0);
      chk({rd[3:0], linearAddressing, interfaceDetected, softPowerDown}, 7'h36);
      if (r == 0)
      begin
        av(1'h0, 4'h2, 32'h0);
        chk(rd, 32'h0);
        av(1'h1, AV_ACCESS, {16'h1, 10'h0, ADDR_IRQCFG});
        av(1'h0, AV_LINKDATA, 32'h0);
        chk(rd, 32'h2);
        acc(8'h10);
        wt(2);
        chk({softPowerDown, oscBufferOn, currentSinksOn}, 3'h4);
        acc(8'h00);
        wt(500);
        chk(softPowerDown, 1'h1);
        wt(40);
        chk(softPowerDown, 1'h0);
        acc(8'h20);
        wt(2);
        chk({standbyActive, clockBufferOn, oscillatorOn}, 3'h5);
        acc(8'h00);
        for (int p = 0; p < 5; p++)
        begin
          wt(8);
          chk(standbyActive, p < 4);
          oscInput <= 1'h1;
          wt(3);
          oscInput <= 1'h0;
        end
        repeat (6)
        begin
          v = $random(seed);
          receiverInUse <= v[1];
          acc({4'h0, v[0], 3'h0});
          wt(3);
          chk(receiverPowered, !v[0] | v[1]);
        end
        // left in soft power-down so the restart must clear it
        acc(8'h10);
      end
    end
    supplyOk <= 1'h0;
    wt(4);
    chk(phase, PSS_HARD_PD);
    supplyOk <= 1'h1;
    seq;
    report_and_stop;
  end
endmodule // power_startup_sequencer_tb
`default_nettype wire
